/* File: design/uif_core.sv */
/*
 * prioritized interrupt status and line format control with a wishbone slave.
 * assumes source levels and event pulses come from the rest of the uart,
 * all synchronous to ref_clk.
 */
// Decided for this implementation: the Wishbone register port and the register offsets.
// Functional notes
// R01: status read returns code of highest pending interrupt in bits 5:0
// R02: pending interrupt holds; lower level shows only after service and re-read
// R03: line status is level 1, code bits 2 and 1 set
// R04: data ready level 2 code 04; receive timeout level 2 code 0C
// R05: transmit empty level 3 code 02; modem status level 4 code 00
// R06: xoff or special character level 5 code 10; flow change level 6 code 20
// R07: bits 7:6 read one when fifos enabled, zero otherwise, default zero
// R08: bits 5:4 reported only while enhanced enable is set
// R09: xoff status stays set until a matching xon arrives
// R10: bits 3:1 name source at levels 1 to 3, default zero
// R11: bit 0 low while pending, one when idle and after reset
// R12: format bit 7 enables divisor latch and enhanced register entry
// R13: format bit 6 forces serial output low until cleared
// R14: bit 3 clear no parity; 001 odd; 011 even
// R15: pattern 111 forces parity bit to zero
// R16: stop select gives 1, 1.5 for five bits, or 2 stop bits
// R17: bits 1:0 give word length five to eight
// R18: pattern 101 forces parity to one, odd uses 001
// R19: transmit empty clears on status read or holding register write
// R20: fifo enable bit selects fifo mode and drives fifo status bits
`timescale 1ns/100ps
`default_nettype none
module uif_core
    import uif_pkg::*;
(
    input  wire logic        ref_clk,
    input  wire logic        reset_n,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic        wb_we_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    output var  logic [31:0] wb_dat_o,
    output var  logic        wb_ack_o,
    input  wire uif_src_t    src_i,
    input  wire logic        tx_empty_evt_i,
    input  wire logic        xoff_evt_i,
    input  wire logic        xon_evt_i,
    input  wire logic        flow_evt_i,
    input  wire logic        tx_serial_i,
    output var  logic        tx_line_o,
    output var  uif_fmt_t    fmt_o,
    output var  logic        fifo_enable_o,
    output var  logic        enh_gate_o,
    output var  logic [7:0]  hold_data_o,
    output var  logic        hold_load_o
);
    logic [7:0]  serial_line_format_control_r;
    logic [7:0]  ctl_r;
    logic        ack_r;
    logic [31:0] dat_r;
    logic [7:0]  transmit_holding_reg_r;
    logic        hold_load_r;
    logic        thre_r;
    logic        xoff_r;
    logic        flow_r;
    logic        tx_line_r;
    uif_level_t  cur_r;
    uif_level_t  cur_nxt;
    uif_level_t  best;
    logic        req;
    logic        take;
    logic        wr_take;
    logic        rd_take;
    logic        enh_on;
    logic        hold_take;
    logic [7:0]  interrupt_source_status;
    logic [5:0]  status_code;

    assign req      = wb_cyc_i && wb_stb_i;
    assign take     = req && ack_r;
    assign wr_take  = take && wb_we_i && wb_sel_i[0];
    assign rd_take   = take && !wb_we_i && wb_adr_i == UIF_OFS_STATUS;
    assign hold_take = wr_take && wb_adr_i == UIF_OFS_HOLD;
    assign enh_on    = ctl_r[UIF_CTL_ENH_EN];

    assign wb_ack_o      = ack_r;
    assign wb_dat_o      = dat_r;
    assign tx_line_o     = tx_line_r;
    assign fifo_enable_o = ctl_r[UIF_CTL_FIFO_EN];
    assign enh_gate_o    = serial_line_format_control_r[UIF_FMT_DLAB];
    assign hold_data_o   = transmit_holding_reg_r;
    assign hold_load_o   = hold_load_r;

    function automatic logic lvl_active(input uif_level_t l);
        case (l)
            UIF_LVL_LINE:  lvl_active = src_i.line_status;
            UIF_LVL_RXDAT: lvl_active = src_i.rx_ready;
            UIF_LVL_RXTO:  lvl_active = src_i.rx_timeout;
            UIF_LVL_THRE:  lvl_active = thre_r;
            UIF_LVL_MODEM: lvl_active = src_i.modem;
            // R08: enhanced sources gated
            UIF_LVL_XOFF:  lvl_active = enh_on && (xoff_r || src_i.special_char);
            UIF_LVL_FLOW:  lvl_active = enh_on && flow_r;
            default:       lvl_active = 1'b0;
        endcase
    endfunction

    // R01: highest pending level wins
    always_comb begin
        best = UIF_LVL_NONE;
        for (int i = 7; i >= 1; i--) begin
            if (lvl_active(uif_level_t'(i[2:0]))) begin
                best = uif_level_t'(i[2:0]);
            end
        end
    end

    // R02: hold current level while its source stands
    always_comb begin
        cur_nxt = cur_r;
        if (!lvl_active(cur_r)) begin
            cur_nxt = best;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            cur_r <= UIF_LVL_NONE;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    always_comb begin
        case (cur_r)
            // R03: line status code
            UIF_LVL_LINE:  status_code = UIF_CODE_LINE;
            // R04: receive codes
            UIF_LVL_RXDAT: status_code = UIF_CODE_RXDAT;
            UIF_LVL_RXTO:  status_code = UIF_CODE_RXTO;
            // R05: transmit and modem codes
            UIF_LVL_THRE:  status_code = UIF_CODE_THRE;
            UIF_LVL_MODEM: status_code = UIF_CODE_MODEM;
            // R06: enhanced codes
            UIF_LVL_XOFF:  status_code = UIF_CODE_XOFF;
            UIF_LVL_FLOW:  status_code = UIF_CODE_FLOW;
            // R11: idle reads bit 0 high
            default:       status_code = UIF_CODE_NONE;
        endcase
    end

    // R07: fifo status bits
    // R20: follow fifo enable
    assign interrupt_source_status = {{2{ctl_r[UIF_CTL_FIFO_EN]}}, status_code};

    // bus answer one cycle after the request, dropped the next cycle
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req && !ack_r;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !ack_r) begin
            case (wb_adr_i)
                // R10: source bits via code
                UIF_OFS_STATUS: dat_r <= {24'h00_0000, interrupt_source_status};
                UIF_OFS_FORMAT: dat_r <= {24'h00_0000, serial_line_format_control_r};
                UIF_OFS_CTL:    dat_r <= {24'h00_0000, ctl_r};
                default:        dat_r <= 32'h0000_0000;
            endcase
        end
    end

    // R12: divisor latch and enhanced entry bit
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            serial_line_format_control_r <= UIF_FORMAT_RST;
        end else if (wr_take && wb_adr_i == UIF_OFS_FORMAT) begin
            serial_line_format_control_r <= wb_dat_i[7:0];
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            ctl_r <= UIF_CTL_RST;
        end else if (wr_take && wb_adr_i == UIF_OFS_CTL) begin
            ctl_r <= wb_dat_i[7:0] & 8'h11;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            transmit_holding_reg_r <= UIF_HOLD_RST;
            hold_load_r            <= 1'b0;
        end else begin
            hold_load_r <= hold_take;
            if (hold_take) begin
                transmit_holding_reg_r <= wb_dat_i[7:0];
            end
        end
    end

    // R19: transmit empty set wins over clear
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            thre_r <= 1'b0;
        end else if (tx_empty_evt_i) begin
            thre_r <= 1'b1;
        end else if (hold_take || (rd_take && cur_r == UIF_LVL_THRE)) begin
            thre_r <= 1'b0;
        end
    end

    // R09: xoff held until xon
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            xoff_r <= 1'b0;
        end else if (xoff_evt_i) begin
            xoff_r <= 1'b1;
        end else if (xon_evt_i) begin
            xoff_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            flow_r <= 1'b0;
        end else if (flow_evt_i) begin
            flow_r <= 1'b1;
        end else if (rd_take && cur_r == UIF_LVL_FLOW) begin
            flow_r <= 1'b0;
        end
    end

    // R13: break forces line low
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            tx_line_r <= 1'b1;
        end else begin
            tx_line_r <= serial_line_format_control_r[UIF_FMT_BRK] ? 1'b0 : tx_serial_i;
        end
    end

    uif_fmt_decode u_fmt (
        .ref_clk (ref_clk),
        .reset_n (reset_n),
        .fmt_byte(serial_line_format_control_r),
        .fmt_r   (fmt_o)
    );

    sequence s_status_read;
        req && !ack_r && !wb_we_i && wb_adr_i == UIF_OFS_STATUS;
    endsequence

    sequence s_answer;
        ##1 wb_ack_o;
    endsequence

    ack_one_cycle_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // bus answer dropped after one cycle
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    idle_bit_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R11
        (s_status_read and cur_r == UIF_LVL_NONE) |-> s_answer ##0 wb_dat_o[5:0] == 6'h01)
        else $error("idle status does not read 01");
    fifo_bits_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R07
        s_status_read |-> s_answer ##0 wb_dat_o[7:6] == {2{$past(ctl_r[0])}})
        else $error("fifo bits do not follow fifo enable");
    line_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R03
        (s_status_read and cur_r == UIF_LVL_LINE) |-> s_answer ##0 wb_dat_o[7:0] == {{2{$past(ctl_r[0])}}, 6'h06})
        else $error("line status code wrong");
    rx_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R04
        (s_status_read and cur_r == UIF_LVL_RXDAT) |-> s_answer ##0 wb_dat_o[5:0] == 6'h04)
        else $error("data ready code wrong");
    thre_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R05
        (s_status_read and cur_r == UIF_LVL_THRE) |-> s_answer ##0 wb_dat_o[5:0] == 6'h02)
        else $error("transmit empty code wrong");
    xoff_code_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R06
        (s_status_read and cur_r == UIF_LVL_XOFF) |-> s_answer ##0 wb_dat_o[5:0] == 6'h10)
        else $error("xoff code wrong");
    read_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
        (rd_take && cur_r == UIF_LVL_THRE && !tx_empty_evt_i) |=> !thre_r)
        else $error("transmit empty not cleared by status read");
    level_lock_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R02
        (cur_r != UIF_LVL_NONE && lvl_active(cur_r)) |=> cur_r == $past(cur_r))
        else $error("pending level replaced while still active");
    line_first_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R01
        (cur_r == UIF_LVL_NONE && src_i.line_status) |=> cur_r == UIF_LVL_LINE)
        else $error("line status not taken first");
    thre_clear_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R19
        (hold_take && !tx_empty_evt_i) |=> !thre_r)
        else $error("transmit empty not cleared by write");
    xoff_hold_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R09
        (xoff_r && !xon_evt_i) |=> xoff_r)
        else $error("xoff status dropped without xon");
    enh_gate_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R08
        (!enh_on && $past(!enh_on)) |-> (cur_r != UIF_LVL_XOFF && cur_r != UIF_LVL_FLOW))
        else $error("enhanced level shown while disabled");
    break_low_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R13
        serial_line_format_control_r[UIF_FMT_BRK] [*2] |-> !tx_line_o)
        else $error("break does not hold line low");
endmodule : uif_core
`default_nettype wire

/* File: design/uif_fmt_decode.sv */
/*
 * decodes the line format control byte into a registered format struct.
 * assumes the byte comes from a register in the same clock domain.
 */
`timescale 1ns/100ps
`default_nettype none
module uif_fmt_decode
    import uif_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire logic [7:0] fmt_byte,
    output var  uif_fmt_t   fmt_r
);
    uif_fmt_t fmt_nxt;

    always_comb begin
        fmt_nxt       = '0;
        // R12: latch access bit
        fmt_nxt.dlab  = fmt_byte[UIF_FMT_DLAB];
        fmt_nxt.brk   = fmt_byte[UIF_FMT_BRK];
        // R17: word length
        fmt_nxt.word_bits = UIF_WORD_BASE + {2'h0, fmt_byte[1:0]};
        // R16: stop length
        if (!fmt_byte[UIF_FMT_STOP]) begin
            fmt_nxt.stop_halves = UIF_STOP_ONE;
        end else if (fmt_byte[1:0] == 2'h0) begin
            fmt_nxt.stop_halves = UIF_STOP_ONE_HALF;
        end else begin
            fmt_nxt.stop_halves = UIF_STOP_TWO;
        end
        // R14: parity select
        case (fmt_byte[5:3])
            3'h1: fmt_nxt.parity = UIF_PAR_ODD;
            3'h3: fmt_nxt.parity = UIF_PAR_EVEN;
            // R18: stick one
            3'h5: fmt_nxt.parity = UIF_PAR_MARK;
            // R15: stick zero
            3'h7: fmt_nxt.parity = UIF_PAR_SPACE;
            default: fmt_nxt.parity = UIF_PAR_NONE;
        endcase
    end

    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            fmt_r <= '0;
            fmt_r.word_bits <= UIF_WORD_BASE;
            fmt_r.stop_halves <= UIF_STOP_ONE;
        end else begin
            fmt_r <= fmt_nxt;
        end
    end

    // R18: stick one decode
    stick_one_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R18
        fmt_byte[5:3] == 3'h5 |=> fmt_r.parity == UIF_PAR_MARK)
        else $error("stick one parity not decoded");
    // R16: half stop for five bits
    half_stop_a: assert property (@(posedge ref_clk) disable iff (!reset_n) // R16
        (fmt_byte[2] && fmt_byte[1:0] == 2'h0) |=> fmt_r.stop_halves == UIF_STOP_ONE_HALF)
        else $error("five bit word lacks one and a half stop bits");
endmodule : uif_fmt_decode
`default_nettype wire

/* File: design/uif_pkg.sv */
/*
 * shared constants and types for the interrupt status and line format block.
 * assumes a 32-bit classic wishbone register bus and one 50 MHz clock.
 */
`default_nettype none
package uif_pkg;
    // register byte offsets
    localparam logic [7:0] UIF_OFS_STATUS = 8'h00;
    localparam logic [7:0] UIF_OFS_FORMAT = 8'h04;
    localparam logic [7:0] UIF_OFS_CTL    = 8'h08;
    localparam logic [7:0] UIF_OFS_HOLD   = 8'h0C;
    // reset values
    localparam logic [7:0] UIF_FORMAT_RST = 8'h00;
    localparam logic [7:0] UIF_CTL_RST    = 8'h00;
    localparam logic [7:0] UIF_HOLD_RST   = 8'h00;
    // field positions
    localparam int UIF_FMT_DLAB    = 7;
    localparam int UIF_FMT_BRK     = 6;
    localparam int UIF_FMT_STOP    = 2;
    localparam int UIF_CTL_FIFO_EN = 0;
    localparam int UIF_CTL_ENH_EN  = 4;
    // status codes on bits 5:0
    localparam logic [5:0] UIF_CODE_NONE  = 6'h01;
    localparam logic [5:0] UIF_CODE_LINE  = 6'h06;
    localparam logic [5:0] UIF_CODE_RXDAT = 6'h04;
    localparam logic [5:0] UIF_CODE_RXTO  = 6'h0C;
    localparam logic [5:0] UIF_CODE_THRE  = 6'h02;
    localparam logic [5:0] UIF_CODE_MODEM = 6'h00;
    localparam logic [5:0] UIF_CODE_XOFF  = 6'h10;
    localparam logic [5:0] UIF_CODE_FLOW  = 6'h20;
    // stop length in half bit times
    localparam logic [2:0] UIF_STOP_ONE      = 3'h2;
    localparam logic [2:0] UIF_STOP_ONE_HALF = 3'h3;
    localparam logic [2:0] UIF_STOP_TWO      = 3'h4;
    localparam logic [3:0] UIF_WORD_BASE     = 4'h5;

    typedef enum logic [2:0] {
        UIF_LVL_NONE  = 3'b000,
        UIF_LVL_LINE  = 3'b001,
        UIF_LVL_RXDAT = 3'b010,
        UIF_LVL_RXTO  = 3'b011,
        UIF_LVL_THRE  = 3'b100,
        UIF_LVL_MODEM = 3'b101,
        UIF_LVL_XOFF  = 3'b110,
        UIF_LVL_FLOW  = 3'b111
    } uif_level_t;

    typedef enum logic [2:0] {
        UIF_PAR_NONE  = 3'b000,
        UIF_PAR_ODD   = 3'b001,
        UIF_PAR_EVEN  = 3'b010,
        UIF_PAR_MARK  = 3'b011,
        UIF_PAR_SPACE = 3'b100
    } uif_parity_t;

    typedef struct packed {
        logic line_status;
        logic rx_ready;
        logic rx_timeout;
        logic modem;
        logic special_char;
    } uif_src_t;

    typedef struct packed {
        logic        dlab;
        logic        brk;
        uif_parity_t parity;
        logic [2:0]  stop_halves;
        logic [3:0]  word_bits;
    } uif_fmt_t;
endpackage : uif_pkg
`default_nettype wire

/* File: verif/tb_uif_core.sv */
/*
 * self-checking bench for the status and line format block.
 * assumes one 50 MHz clock and the far-side model in uif_far_model.
 */
`timescale 1ns/100ps
`default_nettype none
module tb_uif_core;
    import uif_pkg::*;
    logic        ref_clk, reset_n, wb_we, wb_cyc, wb_stb, wb_ack_o, tx_line_o;
    logic        fifo_enable_o, enh_gate_o, hold_load_o, ser, ser_d;
    logic [7:0]  wb_adr, v, hold_data_o;
    logic [31:0] wb_dat, wb_dat_o, rdat, seed;
    logic [3:0]  wb_sel, evt_req, evt;
    uif_src_t    src_req, src;
    uif_fmt_t    fmt_o;
    int          err_count, num_checks;

    uif_core i_uif_core (.ref_clk(ref_clk), .reset_n(reset_n), .wb_adr_i(wb_adr), .wb_dat_i(wb_dat),
        .wb_sel_i(wb_sel), .wb_we_i(wb_we), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .src_i(src), .tx_empty_evt_i(evt[0]), .xoff_evt_i(evt[1]), .xon_evt_i(evt[2]),
        .flow_evt_i(evt[3]), .tx_serial_i(ser), .tx_line_o(tx_line_o), .fmt_o(fmt_o),
        .fifo_enable_o(fifo_enable_o), .enh_gate_o(enh_gate_o), .hold_data_o(hold_data_o),
        .hold_load_o(hold_load_o));
    uif_far_model i_uif_far_model (.ref_clk(ref_clk), .reset_n(reset_n), .src_req(src_req),
        .evt_req(evt_req), .src_o(src), .evt_o(evt), .serial_o(ser));

    always @(posedge ref_clk) ser_d <= ser;

    task automatic conclude;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : conclude

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        num_checks++;
        if (got !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wb(input logic we, input logic [7:0] adr, input logic [7:0] dat, input logic [3:0] sel);
        int n;
        @(posedge ref_clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= we;
        wb_adr <= adr;
        wb_dat <= {24'h0, dat};
        wb_sel <= sel;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 20);
        rdat = wb_dat_o;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        if (wb_ack_o !== 1'h1) begin
            err_count++;
            conclude();
        end
    endtask : wb

    task automatic rd_stat(input logic [7:0] exp);
        wb(1'h0, UIF_OFS_STATUS, 8'h00, 4'hF);
        chk("status", {24'h0, exp}, rdat);
    endtask : rd_stat

    task automatic setsrc(input uif_src_t s);
        @(posedge ref_clk);
        src_req <= s;
        repeat (4) @(posedge ref_clk);
    endtask : setsrc

    task automatic pulse(input int idx);
        @(posedge ref_clk);
        evt_req <= 4'h1 << idx;
        @(posedge ref_clk);
        evt_req <= 4'h0;
        repeat (4) @(posedge ref_clk);
    endtask : pulse

    function automatic logic [31:0] xs(input logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction : xs

    function automatic uif_fmt_t exp_fmt(input logic [7:0] b);
        uif_fmt_t f;
        f.dlab = b[7];
        f.brk = b[6];
        f.parity = !b[3] ? UIF_PAR_NONE : b[5:4] == 2'h0 ? UIF_PAR_ODD :
                   b[5:4] == 2'h1 ? UIF_PAR_EVEN : b[5:4] == 2'h2 ? UIF_PAR_MARK : UIF_PAR_SPACE;
        f.stop_halves = !b[2] ? UIF_STOP_ONE : b[1:0] == 2'h0 ? UIF_STOP_ONE_HALF : UIF_STOP_TWO;
        f.word_bits = UIF_WORD_BASE + {2'h0, b[1:0]};
        return f;
    endfunction : exp_fmt

    initial begin
        ref_clk = 1'h0;
        forever #10 ref_clk = ~ref_clk;
    end

    initial begin
        reset_n = 1'h0;
        {wb_we, wb_cyc, wb_stb, wb_adr, wb_dat, wb_sel, evt_req} = '0;
        src_req = '0;
        seed = 32'hF37B;
        err_count = 0;
        num_checks = 0;
        repeat (5) @(posedge ref_clk);
        chk("line in reset", 32'h1, {31'h0, tx_line_o});
        reset_n <= 1'h1;
        rd_stat(8'h01);
        wb(1'h0, UIF_OFS_FORMAT, 8'h00, 4'hF);
        chk("format", {24'h0, UIF_FORMAT_RST}, rdat);
        chk("decode", {20'h0, exp_fmt(8'h00)}, {20'h0, fmt_o});
        wb(1'h1, UIF_OFS_STATUS, 8'hFF, 4'hF);
        rd_stat(8'h01);
        wb(1'h1, 8'h10, 8'hFF, 4'hF);
        wb(1'h0, 8'h10, 8'h00, 4'hF);
        chk("unmapped", 32'h0, rdat);
        wb(1'h1, UIF_OFS_FORMAT, 8'h03, 4'hE);
        wb(1'h0, UIF_OFS_FORMAT, 8'h00, 4'hF);
        chk("format", 32'h0, rdat);
        for (int i = 0; i < 24; i++) begin
            seed = xs(seed);
            v = seed[7:0];
            if (i < 8) v[5:0] = {i[2:0], i[2:0]};
            wb(1'h1, UIF_OFS_FORMAT, v, 4'hF);
            repeat (2) @(posedge ref_clk);
            chk("decode", {20'h0, exp_fmt(v)}, {20'h0, fmt_o});
            chk("gate", {31'h0, v[7]}, {31'h0, enh_gate_o});
            wb(1'h0, UIF_OFS_FORMAT, 8'h00, 4'hF);
            chk("format", {24'h0, v}, rdat);
        end
        wb(1'h1, UIF_OFS_FORMAT, 8'h43, 4'hF);
        repeat (2) @(posedge ref_clk);
        repeat (6) begin
            @(negedge ref_clk);
            chk("break", 32'h0, {31'h0, tx_line_o});
        end
        wb(1'h1, UIF_OFS_FORMAT, 8'h03, 4'hF);
        repeat (2) @(posedge ref_clk);
        repeat (6) begin
            @(negedge ref_clk);
            chk("line", {31'h0, ser_d}, {31'h0, tx_line_o});
        end
        wb(1'h1, UIF_OFS_CTL, 8'h11, 4'hF);
        repeat (2) @(posedge ref_clk);
        chk("fifo", 32'h1, {31'h0, fifo_enable_o});
        setsrc(5'b11110);
        rd_stat(8'hC6);
        rd_stat(8'hC6);
        setsrc(5'b01110);
        rd_stat(8'hC4);
        setsrc(5'b00110);
        rd_stat(8'hCC);
        setsrc(5'b00010);
        rd_stat(8'hC0);
        setsrc(5'b00000);
        rd_stat(8'hC1);
        pulse(0);
        rd_stat(8'hC2);
        rd_stat(8'hC1);
        pulse(1);
        rd_stat(8'hD0);
        rd_stat(8'hD0);
        pulse(2);
        rd_stat(8'hC1);
        setsrc(5'b00001);
        rd_stat(8'hD0);
        setsrc(5'b00000);
        pulse(3);
        rd_stat(8'hE0);
        rd_stat(8'hC1);
        pulse(0);
        wb(1'h1, UIF_OFS_HOLD, 8'hA5, 4'hF);
        @(posedge ref_clk);
        chk("load", 32'h1, {31'h0, hold_load_o});
        @(posedge ref_clk);
        chk("load once", 32'h0, {31'h0, hold_load_o});
        chk("holding", 32'hA5, {24'h0, hold_data_o});
        rd_stat(8'hC1);
        wb(1'h1, UIF_OFS_CTL, 8'h01, 4'hF);
        pulse(1);
        wb(1'h0, UIF_OFS_STATUS, 8'h00, 4'hF);
        chk("enhanced bits", 32'h0, rdat & 32'h30);
        pulse(2);
        wb(1'h1, UIF_OFS_CTL, 8'h00, 4'hF);
        rd_stat(8'h01);
        // mid-run reset with break and latch access set
        wb(1'h1, UIF_OFS_FORMAT, 8'hC3, 4'hF);
        @(posedge ref_clk);
        reset_n <= 1'h0;
        repeat (2) @(posedge ref_clk);
        reset_n <= 1'h1;
        chk("line after reset", 32'h1, {31'h0, tx_line_o});
        chk("gate after reset", 32'h0, {31'h0, enh_gate_o});
        wb(1'h0, UIF_OFS_FORMAT, 8'h00, 4'hF);
        chk("format after reset", {24'h0, UIF_FORMAT_RST}, rdat);
        rd_stat(8'h01);
        conclude();
    end
endmodule : tb_uif_core
`default_nettype wire

/* File: verif/uif_far_model.sv */
/*
 * far-side model: source levels, event pulses and transmitter serial data.
 * assumes the bench sets requests by non-blocking assignment at ref_clk edges.
 */
`timescale 1ns/100ps
`default_nettype none
module uif_far_model
    import uif_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic       reset_n,
    input  wire uif_src_t   src_req,
    input  wire logic [3:0] evt_req,
    output var  uif_src_t   src_o,
    output var  logic [3:0] evt_o,
    output var  logic       serial_o
);
    logic [7:0] lfsr_r;

    // serial data takes a new pseudo-random bit every cycle so a stuck line shows
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            lfsr_r <= 8'h5A;
        end else begin
            lfsr_r <= {lfsr_r[6:0], lfsr_r[7] ^ lfsr_r[5] ^ lfsr_r[4] ^ lfsr_r[3]};
        end
    end

    // levels and pulses registered once, as from the rest of the uart
    always_ff @(posedge ref_clk) begin
        if (!reset_n) begin
            src_o <= '0;
            evt_o <= 4'h0;
        end else begin
            src_o <= src_req;
            evt_o <= evt_req;
        end
    end

    assign serial_o = lfsr_r[0];
endmodule : uif_far_model
`default_nettype wire
